// ### stb_pkg.sv
package stb_pkg;
    localparam logic [2:0] MODE_SER_LOCAL = 3'h6;
    localparam logic [2:0] MODE_SER_UTC   = 3'h7;
    localparam logic [2:0] MODE_DCF_CET   = 3'h3;
    localparam logic [2:0] MODE_DCF_WORLD = 3'h4;

    localparam int          CLK_HZ       = 250_000_000;
    localparam int          BAUD_RATE    = 9600;
    localparam int          BAUD_DIV     = CLK_HZ / BAUD_RATE;
    localparam int          DATA_BITS    = 8;
    localparam logic [7:0]  CHR_STX      = 8'h02;
    localparam logic [7:0]  CHR_ETX      = 8'h03;
    localparam logic [2:0]  SER_FIELDS   = 3'h7;

    // Pulse train timing in ms: 100 ms is a zero, 200 ms a one
    localparam int          DCF_ONE_MS   = 150;
    localparam int          DCF_GAP_MS   = 1500;
    localparam int          DCF_ONE_CYC  = (CLK_HZ / 1000) * DCF_ONE_MS;
    localparam int          DCF_GAP_CYC  = (CLK_HZ / 1000) * DCF_GAP_MS;
    localparam logic [5:0]  DCF_BITS     = 6'h3B;
    localparam int          DCF_DST_BIT  = 17;
    localparam int          DCF_MIN_LSB  = 21;
    localparam int          DCF_HOUR_LSB = 29;
    localparam int          DCF_DAY_LSB  = 36;
    localparam int          DCF_MON_LSB  = 45;
    localparam int          DCF_YEAR_LSB = 50;

    localparam logic signed [5:0] CET_STD_OFF = 6'sh01;
    localparam logic signed [5:0] CET_DST_OFF = 6'sh02;
    localparam logic signed [5:0] DST_EXTRA   = 6'sh01;

    typedef enum logic [1:0] {
        RX_IDLE, RX_START, RX_DATA, RX_STOP
    } stb_rx_state_t;
endpackage

// ### stb_uart_rx.sv
`timescale 1ns/1ps
module stb_uart_rx
    import stb_pkg::*;
#(
    parameter int BAUD_CYC = BAUD_DIV
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       rxd,
    output logic            start_edge,
    output logic [7:0]      rx_byte,
    output logic            rx_valid
);
    stb_rx_state_t state, next_state;
    logic [15:0]   cnt, next_cnt;
    logic [2:0]    bit_idx, next_bit_idx;
    logic [7:0]    shreg, next_shreg;
    logic          next_valid;

    always_comb begin
        next_state   = state;
        next_cnt     = (cnt != 16'h0000) ? cnt - 16'h0001 : cnt;
        next_bit_idx = bit_idx;
        next_shreg   = shreg;
        next_valid   = 1'b0;
        start_edge   = 1'b0;
        unique case (state)
            RX_IDLE: begin
                if (!rxd) begin
                    start_edge = 1'b1;
                    next_state = RX_START;
                    next_cnt   = 16'(BAUD_CYC / 2);
                end
            end
            RX_START: begin
                if (cnt == 16'h0000) begin
                    next_state   = rxd ? RX_IDLE : RX_DATA;
                    next_cnt     = 16'(BAUD_CYC - 1);
                    next_bit_idx = 3'h0;
                end
            end
            RX_DATA: begin
                if (cnt == 16'h0000) begin
                    next_shreg = {rxd, shreg[7:1]};
                    next_cnt   = 16'(BAUD_CYC - 1);
                    if (bit_idx == 3'(DATA_BITS - 1)) begin
                        next_state = RX_STOP;
                    end
                    next_bit_idx = bit_idx + 3'h1;
                end
            end
            RX_STOP: begin
                if (cnt == 16'h0000) begin
                    next_state = RX_IDLE;
                    next_valid = rxd;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state    <= RX_IDLE;
            cnt      <= 16'h0000;
            bit_idx  <= 3'h0;
            shreg    <= 8'h00;
            rx_valid <= 1'b0;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            bit_idx  <= next_bit_idx;
            shreg    <= next_shreg;
            rx_valid <= next_valid;
        end
    end

    assign rx_byte = shreg;
endmodule

// ### stb_time_base.sv
`timescale 1ns/1ps
module stb_time_base
    import stb_pkg::*;
#(
    parameter int BAUD_CYC = BAUD_DIV,
    parameter int ONE_CYC  = DCF_ONE_CYC,
    parameter int GAP_CYC  = DCF_GAP_CYC
) (
    input  wire logic              SYS_CLK,
    input  wire logic              ARST_N,
    input  wire logic [2:0]        SYNC_MODE,
    input  wire logic signed [4:0] CFG_OFFSET,
    input  wire logic              CHG_VALID,
    input  wire logic [3:0]        CHG_SD_MONTH,
    input  wire logic [4:0]        CHG_SD_DAY,
    input  wire logic [4:0]        CHG_SD_HOUR,
    input  wire logic [3:0]        CHG_DS_MONTH,
    input  wire logic [4:0]        CHG_DS_DAY,
    input  wire logic [4:0]        CHG_DS_HOUR,
    input  wire logic              SER_RXD,
    input  wire logic              DCF_PULSE,
    output logic [5:0]             LOCAL_SEC,
    output logic [5:0]             LOCAL_MIN,
    output logic [4:0]             LOCAL_HOUR,
    output logic [4:0]             LOCAL_DAY,
    output logic [3:0]             LOCAL_MONTH,
    output logic [6:0]             LOCAL_YEAR,
    output logic [4:0]             UTC_HOUR,
    output logic [4:0]             UTC_DAY,
    output logic [3:0]             UTC_MONTH,
    output logic [6:0]             UTC_YEAR,
    output logic                   DST_ACTIVE,
    output logic signed [5:0]      APPLIED_OFFSET,
    output logic                   TIME_SET
);
    function automatic logic [4:0] days_in(input logic [3:0] m,
                                           input logic [6:0] y);
        unique case (m)
            4'h2:                      days_in = (y[1:0] == 2'h0) ? 5'd29 : 5'd28;
            4'h4, 4'h6, 4'h9, 4'hB:    days_in = 5'd30;
            default:                   days_in = 5'd31;
        endcase
    endfunction

    // Shifts {hour,day,month,year} by whole hours, carrying into the date
    function automatic logic [20:0] shift_hours(input logic [20:0] t,
                                                input logic signed [5:0] dh);
        logic signed [6:0] h;
        logic [4:0]        d;
        logic [3:0]        m;
        logic [6:0]        y;
        h = 7'(signed'({2'b00, t[20:16]})) + 7'(dh);
        d = t[15:11];
        m = t[10:7];
        y = t[6:0];
        if (h < 0) begin
            h = h + 7'sd24;
            if (d <= 5'd1) begin
                if (m <= 4'h1) begin
                    m = 4'hC;
                    y = (y == 7'h00) ? 7'd99 : y - 7'h01;
                end else begin
                    m = m - 4'h1;
                end
                d = days_in(m, y);
            end else begin
                d = d - 5'd1;
            end
        end else if (h >= 7'sd24) begin
            h = h - 7'sd24;
            if (d >= days_in(m, y)) begin
                d = 5'd1;
                if (m >= 4'hC) begin
                    m = 4'h1;
                    y = (y >= 7'd99) ? 7'h00 : y + 7'h01;
                end else begin
                    m = m + 4'h1;
                end
            end else begin
                d = d + 5'd1;
            end
        end
        shift_hours = {h[4:0], d, m, y};
    endfunction

    function automatic logic [6:0] bcd(input logic [7:0] v);
        bcd = 7'(v[3:0]) + 7'(v[7:4]) * 7'd10;
    endfunction

    // Serial string collector
    logic       start_edge;
    logic [7:0] rx_byte;
    logic       rx_valid;

    stb_uart_rx #(.BAUD_CYC(BAUD_CYC)) u_rx (
        .clk        (SYS_CLK),
        .arst_n     (ARST_N),
        .rxd        (SER_RXD),
        .start_edge (start_edge),
        .rx_byte    (rx_byte),
        .rx_valid   (rx_valid)
    );

    logic [2:0] fld, next_fld;
    logic [7:0] sbuf [6], next_sbuf [6];
    logic       ser_mode;
    logic       ser_commit;

    assign ser_mode = (SYNC_MODE == MODE_SER_LOCAL) ||
                      (SYNC_MODE == MODE_SER_UTC);
    // Committed on the start edge; the string is complete by then
    assign ser_commit = ser_mode && start_edge && (fld == SER_FIELDS);

    always_comb begin
        next_fld  = fld;
        next_sbuf = sbuf;
        if (ser_commit) begin
            next_fld = 3'h0;
        end else if (rx_valid) begin
            // Binary fields may equal the start code; only idle or a full string resyncs
            if (fld != 3'h0 && fld != SER_FIELDS) begin
                next_sbuf[fld - 3'h1] = rx_byte;
                next_fld = fld + 3'h1;
            end else if (rx_byte == CHR_STX) begin
                next_fld = 3'h1;
            end else begin
                next_fld = 3'h0;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            fld  <= 3'h0;
            sbuf <= '{default: 8'h00};
        end else begin
            fld  <= next_fld;
            sbuf <= next_sbuf;
        end
    end

    // Pulse train decoder
    logic        pulse_d, next_pulse_d;
    logic [28:0] width, next_width;
    logic [5:0]  dbit, next_dbit;
    logic [58:0] dreg, next_dreg;
    logic        dcf_commit;
    logic        dcf_mode;

    assign dcf_mode   = (SYNC_MODE == MODE_DCF_CET) ||
                        (SYNC_MODE == MODE_DCF_WORLD);
    // Minute mark: long gap, then the rising edge of second zero
    assign dcf_commit = dcf_mode && DCF_PULSE && !pulse_d &&
                        width >= 29'(GAP_CYC) && dbit == DCF_BITS;

    always_comb begin
        next_pulse_d = DCF_PULSE;
        next_dbit    = dbit;
        next_dreg    = dreg;
        next_width   = (width == '1) ? width : width + 29'h1;
        if (DCF_PULSE != pulse_d) begin
            next_width = 29'h0;
        end
        if (!DCF_PULSE && pulse_d && dbit < DCF_BITS) begin
            next_dreg[dbit] = (width >= 29'(ONE_CYC));
            next_dbit       = dbit + 6'h1;
        end
        if (DCF_PULSE && !pulse_d && width >= 29'(GAP_CYC)) begin
            next_dbit = 6'h0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pulse_d <= 1'b0;
            width   <= 29'h0;
            dbit    <= 6'h0;
            dreg    <= '0;
        end else begin
            pulse_d <= next_pulse_d;
            width   <= next_width;
            dbit    <= next_dbit;
            dreg    <= next_dreg;
        end
    end

    // Conversion
    logic [20:0]       rx_t;
    logic [5:0]        rx_sec;
    logic [5:0]        rx_min;
    logic [13:0]       key_now, key_sd, key_ds;
    logic              pts_dst, dst, next_dst;
    logic signed [5:0] off, next_off;
    logic [20:0]       loc_t, utc_t;
    logic [5:0]        next_lsec, next_lmin;

    always_comb begin
        if (ser_mode) begin
            rx_sec = sbuf[0][5:0];
            rx_min = sbuf[1][5:0];
            rx_t   = {sbuf[2][4:0], sbuf[3][4:0], sbuf[4][3:0], sbuf[5][6:0]};
        end else begin
            rx_sec = 6'h00;
            rx_min = 6'(bcd({1'b0, dreg[DCF_MIN_LSB +: 7]}));
            rx_t   = {5'(bcd({2'b00, dreg[DCF_HOUR_LSB +: 6]})),
                      5'(bcd({2'b00, dreg[DCF_DAY_LSB +: 6]})),
                      4'(bcd({3'b000, dreg[DCF_MON_LSB +: 5]})),
                      bcd(dreg[DCF_YEAR_LSB +: 8])};
        end
    end

    // Changeover window; a later start than end wraps over the new year
    assign key_now = {rx_t[10:7], rx_t[15:11], rx_t[20:16]};
    assign key_sd  = {CHG_SD_MONTH, CHG_SD_DAY, CHG_SD_HOUR};
    assign key_ds  = {CHG_DS_MONTH, CHG_DS_DAY, CHG_DS_HOUR};
    assign pts_dst = CHG_VALID && ((key_sd <= key_ds) ?
                     (key_now >= key_sd && key_now < key_ds) :
                     (key_now >= key_sd || key_now < key_ds));

    always_comb begin
        next_dst  = dst;
        next_off  = off;
        next_lsec = LOCAL_SEC;
        next_lmin = LOCAL_MIN;
        loc_t     = {LOCAL_HOUR, LOCAL_DAY, LOCAL_MONTH, LOCAL_YEAR};
        utc_t     = {UTC_HOUR, UTC_DAY, UTC_MONTH, UTC_YEAR};
        if (ser_commit || dcf_commit) begin
            next_lsec = rx_sec;
            next_lmin = rx_min;
            if (ser_mode) begin
                next_dst = pts_dst;
                next_off = 6'(CFG_OFFSET) + (pts_dst ? DST_EXTRA : 6'sh00);
            end else if (SYNC_MODE == MODE_DCF_CET) begin
                next_dst = dreg[DCF_DST_BIT];
                next_off = next_dst ? CET_DST_OFF : CET_STD_OFF;
            end else begin
                next_dst = dreg[DCF_DST_BIT];
                next_off = 6'(CFG_OFFSET) + (next_dst ? DST_EXTRA : 6'sh00);
            end
            if (SYNC_MODE == MODE_SER_UTC) begin
                utc_t = rx_t;
                loc_t = shift_hours(rx_t, next_off);
            end else begin
                loc_t = rx_t;
                utc_t = shift_hours(rx_t, -next_off);
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            LOCAL_SEC      <= 6'h00;
            LOCAL_MIN      <= 6'h00;
            {LOCAL_HOUR, LOCAL_DAY, LOCAL_MONTH, LOCAL_YEAR} <= 21'h0;
            {UTC_HOUR, UTC_DAY, UTC_MONTH, UTC_YEAR}         <= 21'h0;
            dst            <= 1'b0;
            off            <= 6'sh00;
            TIME_SET       <= 1'b0;
        end else begin
            LOCAL_SEC      <= next_lsec;
            LOCAL_MIN      <= next_lmin;
            {LOCAL_HOUR, LOCAL_DAY, LOCAL_MONTH, LOCAL_YEAR} <= loc_t;
            {UTC_HOUR, UTC_DAY, UTC_MONTH, UTC_YEAR}         <= utc_t;
            dst            <= next_dst;
            off            <= next_off;
            TIME_SET       <= ser_commit || dcf_commit;
        end
    end

    assign DST_ACTIVE     = dst;
    assign APPLIED_OFFSET = off;

    a_local_pass: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ser_commit && SYNC_MODE == MODE_SER_LOCAL |=>
            LOCAL_HOUR == $past(sbuf[2][4:0]))
        else $error("serial local hour not kept");
    a_utc_pass: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ser_commit && SYNC_MODE == MODE_SER_UTC |=>
            UTC_HOUR == $past(sbuf[2][4:0]))
        else $error("serial utc hour not kept");
    a_ser_offset: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ser_commit |=> APPLIED_OFFSET ==
            6'($past(CFG_OFFSET)) + (DST_ACTIVE ? 6'sh01 : 6'sh00))
        else $error("serial offset wrong");
    a_no_points: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ser_commit && !CHG_VALID |=> !DST_ACTIVE)
        else $error("daylight without changeover points");
    a_cet_fixed: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        dcf_commit && SYNC_MODE == MODE_DCF_CET |=>
            APPLIED_OFFSET == (DST_ACTIVE ? 6'sh02 : 6'sh01))
        else $error("cet offset wrong");
    a_dst_signal: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        dcf_commit |=> DST_ACTIVE == $past(dreg[DCF_DST_BIT]))
        else $error("dst not from signal");
    a_world_off: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        dcf_commit && SYNC_MODE == MODE_DCF_WORLD |=> APPLIED_OFFSET ==
            6'($past(CFG_OFFSET)) + (DST_ACTIVE ? 6'sh01 : 6'sh00))
        else $error("worldwide offset wrong");
    a_etx_set: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ser_mode && start_edge && fld == SER_FIELDS |=> TIME_SET ##1 !TIME_SET)
        else $error("time not set on end-of-text start edge");
    a_utc_calc: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        dcf_commit |=> {UTC_HOUR, UTC_DAY, UTC_MONTH, UTC_YEAR} ==
            shift_hours({LOCAL_HOUR, LOCAL_DAY, LOCAL_MONTH, LOCAL_YEAR},
                        -APPLIED_OFFSET))
        else $error("utc not local minus offset");
endmodule

// ### stb_far_source.sv
`timescale 1ns/1ps
module stb_far_source
    import stb_pkg::*;
#(
    parameter int BIT_CYC = 16
) (
    input  wire logic clk,
    output logic      ser_rxd,
    output logic      dcf_pulse
);
    // Second shrunk to 40 cycles to keep frames short
    localparam int SEC_W  = 40;
    localparam int ONE_W  = 20;
    localparam int ZERO_W = 8;
    localparam int GAP_W  = 200;

    initial begin
        ser_rxd   = 1'b1;
        dcf_pulse = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frm;
        frm = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            ser_rxd = frm[i];
            hold(BIT_CYC);
        end
    endtask

    // Seconds in the low byte; the end marker opens the new second
    task automatic send_string(input logic [47:0] f);
        send_byte(CHR_STX);
        for (int i = 0; i < 6; i++) begin
            send_byte(f[8*i +: 8]);
        end
        send_byte(CHR_ETX);
    endtask

    // Long low stands for the missing pulse of second 59
    task automatic send_minute(input logic [58:0] b, input int n);
        hold(GAP_W);
        for (int i = 0; i < n; i++) begin
            dcf_pulse = 1'b1;
            hold(b[i] ? ONE_W : ZERO_W);
            dcf_pulse = 1'b0;
            hold(b[i] ? SEC_W - ONE_W : SEC_W - ZERO_W);
        end
        hold(GAP_W);
        dcf_pulse = 1'b1;
        hold(ZERO_W);
        dcf_pulse = 1'b0;
    endtask
endmodule

// ### stb_time_base_bench.sv
`timescale 1ns/1ps
module stb_time_base_bench;
    import stb_pkg::*;
    localparam int BCYC = 16;
    logic              clk, rst_n, chg;
    logic [2:0]        mode;
    logic signed [4:0] cfg_off;
    logic [3:0]        sdm, dsm;
    logic [4:0]        sdd, sdh, dsd, dsh;
    wire logic         rxd, pls, dst, tset;
    wire logic [5:0]   lsec, lmin;
    wire logic signed [5:0] aoff;
    wire logic [4:0]   lhr, lday, uhr, uday;
    wire logic [3:0]   lmon, umon;
    wire logic [6:0]   lyr, uyr;
    int num_errors, total_checks, seed, sets;
    int e_ls, e_lm, e_lh, e_ld, e_lo, e_ly, e_uh, e_ud, e_uo, e_uy;
    int e_dst, e_off;

    stb_far_source #(.BIT_CYC(BCYC)) i_src (
        .clk(clk), .ser_rxd(rxd), .dcf_pulse(pls)
    );
    stb_time_base #(.BAUD_CYC(BCYC), .ONE_CYC(15), .GAP_CYC(150)) i_dut (
        .SYS_CLK(clk), .ARST_N(rst_n), .SYNC_MODE(mode),
        .CFG_OFFSET(cfg_off), .CHG_VALID(chg),
        .CHG_SD_MONTH(sdm), .CHG_SD_DAY(sdd), .CHG_SD_HOUR(sdh),
        .CHG_DS_MONTH(dsm), .CHG_DS_DAY(dsd), .CHG_DS_HOUR(dsh),
        .SER_RXD(rxd), .DCF_PULSE(pls),
        .LOCAL_SEC(lsec), .LOCAL_MIN(lmin), .LOCAL_HOUR(lhr),
        .LOCAL_DAY(lday), .LOCAL_MONTH(lmon), .LOCAL_YEAR(lyr),
        .UTC_HOUR(uhr), .UTC_DAY(uday), .UTC_MONTH(umon), .UTC_YEAR(uyr),
        .DST_ACTIVE(dst), .APPLIED_OFFSET(aoff), .TIME_SET(tset)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        if (tset === 1'b1) sets++;
    end

    function automatic int rnd(input int n);
        return int'($unsigned($random(seed)) % n);
    endfunction

    function automatic int mdays(input int y, mo);
        if (mo == 2) return (y % 4 == 0) ? 29 : 28;
        if (mo == 4 || mo == 6 || mo == 9 || mo == 11) return 30;
        return 31;
    endfunction

    function automatic void shift(inout int y, mo, d, h, input int dh);
        h += dh;
        while (h < 0) begin
            h += 24;
            d--;
            if (d == 0) begin
                mo--;
                if (mo == 0) begin
                    mo = 12;
                    y = (y + 99) % 100;
                end
                d = mdays(y, mo);
            end
        end
        while (h > 23) begin
            h -= 24;
            d++;
            if (d > mdays(y, mo)) begin
                d = 1;
                mo++;
                if (mo == 13) begin
                    mo = 1;
                    y = (y + 1) % 100;
                end
            end
        end
    endfunction

    function automatic logic [7:0] bcd(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction

    function automatic logic [58:0] dcf_bits(input int mi, h, d, mo, y,
                                             input logic ds);
        logic [58:0] b;
        logic [7:0]  v;
        b = '0;
        b[DCF_DST_BIT] = ds;
        b[DCF_DST_BIT+1] = ~ds;
        b[20] = 1'b1;
        v = bcd(mi);
        b[DCF_MIN_LSB +: 8] = {^v[6:0], v[6:0]};
        v = bcd(h);
        b[DCF_HOUR_LSB +: 7] = {^v[5:0], v[5:0]};
        v = bcd(d);
        b[DCF_DAY_LSB +: 6] = v[5:0];
        b[42] = 1'b1;
        v = bcd(mo);
        b[DCF_MON_LSB +: 5] = v[4:0];
        b[DCF_YEAR_LSB +: 8] = bcd(y);
        b[58] = ^b[57:36];
        return b;
    endfunction

    function automatic logic in_win(input int mo, d, h);
        int k, s, t;
        k = mo * 10000 + d * 100 + h;
        s = sdm * 10000 + sdd * 100 + sdh;
        t = dsm * 10000 + dsd * 100 + dsh;
        if (!chg) return 1'b0;
        return (s <= t) ? (k >= s && k < t) : (k >= s || k < t);
    endfunction

    task automatic check(input string nm, input logic [6:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %0d seen %0d", nm, exp, seen);
        end
    endtask

    task automatic compare();
        check("local_sec", 7'(lsec), 7'(e_ls));
        check("local_min", 7'(lmin), 7'(e_lm));
        check("local_hour", 7'(lhr), 7'(e_lh));
        check("local_day", 7'(lday), 7'(e_ld));
        check("local_month", 7'(lmon), 7'(e_lo));
        check("local_year", 7'(lyr), 7'(e_ly));
        check("utc_hour", 7'(uhr), 7'(e_uh));
        check("utc_day", 7'(uday), 7'(e_ud));
        check("utc_month", 7'(umon), 7'(e_uo));
        check("utc_year", 7'(uyr), 7'(e_uy));
        check("dst_active", 7'(dst), 7'(e_dst));
        check("offset", 7'(aoff), 7'(e_off));
    endtask

    task automatic cfg(input logic [2:0] m, input int off);
        @(posedge clk);
        #1;
        mode = m;
        cfg_off = 5'(off);
    endtask

    task automatic points(input int a, b, c, d, e, f, input logic v);
        @(posedge clk);
        #1;
        {sdm, sdd, sdh} = {4'(a), 5'(b), 5'(c)};
        {dsm, dsd, dsh} = {4'(d), 5'(e), 5'(f)};
        chg = v;
    endtask

    task automatic set_rx(input int s, mi, h, d, mo, y);
        {e_ls, e_lm, e_lh, e_ld, e_lo, e_ly} = {s, mi, h, d, mo, y};
        {e_uh, e_ud, e_uo, e_uy} = {h, d, mo, y};
    endtask

    task automatic ser(input logic [2:0] m, input int s, mi, h, d, mo, y,
                       input int off);
        int   n;
        logic ok;
        ok = (m == MODE_SER_LOCAL || m == MODE_SER_UTC);
        cfg(m, off);
        n = sets;
        i_src.send_string({8'(y), 8'(mo), 8'(d), 8'(h), 8'(mi), 8'(s)});
        repeat (4) @(posedge clk);
        #1;
        check("commit", 7'(sets - n), 7'(ok));
        if (ok) begin
            set_rx(s, mi, h, d, mo, y);
            e_dst = int'(in_win(mo, d, h));
            e_off = off + e_dst;
            if (m == MODE_SER_UTC)
                shift(e_ly, e_lo, e_ld, e_lh, e_off);
            else
                shift(e_uy, e_uo, e_ud, e_uh, -e_off);
        end
        compare();
    endtask

    task automatic pul(input logic [2:0] m, input int mi, h, d, mo, y,
                       input logic ds, input int off, n);
        int   c;
        logic ok;
        ok = (m == MODE_DCF_CET || m == MODE_DCF_WORLD) && n == 59;
        cfg(m, off);
        c = sets;
        i_src.send_minute(dcf_bits(mi, h, d, mo, y, ds), n);
        repeat (4) @(posedge clk);
        #1;
        check("commit", 7'(sets - c), 7'(ok));
        if (ok) begin
            set_rx(0, mi, h, d, mo, y);
            e_dst = int'(ds);
            e_off = (m == MODE_DCF_CET) ? 1 + e_dst : off + e_dst;
            shift(e_uy, e_uo, e_ud, e_uh, -e_off);
        end
        compare();
    endtask

    task automatic print_verdict();
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        num_errors++;
        print_verdict();
    end

    initial begin
        seed = 99314;
        rst_n = 1'b0;
        chg = 1'b0;
        mode = 3'h0;
        cfg_off = '0;
        {sdm, sdd, sdh, dsm, dsd, dsh} = '0;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        compare();
        points(3, 29, 2, 10, 25, 3, 1'b1);
        ser(MODE_SER_LOCAL, 0, 0, 0, 1, 1, 25, 2);
        ser(MODE_SER_LOCAL, 30, 15, 1, 1, 3, 24, 3);
        ser(MODE_SER_UTC, 59, 59, 23, 31, 12, 99, 3);
        ser(MODE_SER_UTC, 5, 0, 2, 29, 3, 25, -5);
        ser(MODE_SER_LOCAL, 5, 0, 2, 25, 10, 25, 4);
        ser(MODE_SER_LOCAL, 5, 0, 3, 25, 10, 25, 4);
        ser(3'h0, 1, 2, 3, 4, 5, 6, 7);
        ser(MODE_DCF_CET, 1, 2, 3, 4, 5, 6, 7);
        // Southern-hemisphere style window wraps over new year
        points(10, 5, 2, 4, 5, 3, 1'b1);
        ser(MODE_SER_UTC, 0, 0, 22, 15, 1, 30, 11);
        points(10, 5, 2, 4, 5, 3, 1'b0);
        ser(MODE_SER_UTC, 0, 0, 22, 15, 1, 30, 11);
        for (int i = 0; i < 10; i++) begin
            points(rnd(12) + 1, rnd(28) + 1, rnd(24), rnd(12) + 1,
                   rnd(28) + 1, rnd(24), 1'(rnd(2)));
            ser(rnd(2) ? MODE_SER_UTC : MODE_SER_LOCAL, rnd(60), rnd(60),
                rnd(24), rnd(28) + 1, rnd(12) + 1, rnd(100), rnd(25) - 12);
        end
        pul(MODE_DCF_CET, 30, 0, 1, 1, 25, 1'b0, 7, 59);
        pul(MODE_DCF_CET, 59, 1, 1, 3, 24, 1'b1, -3, 59);
        pul(MODE_DCF_WORLD, 0, 0, 1, 1, 0, 1'b0, -5, 59);
        points(1, 1, 0, 12, 31, 23, 1'b1);
        pul(MODE_DCF_WORLD, 10, 22, 31, 12, 99, 1'b0, -4, 59);
        pul(MODE_DCF_WORLD, 10, 12, 10, 6, 25, 1'b1, 9, 59);
        pul(MODE_DCF_WORLD, 1, 2, 3, 4, 5, 1'b1, 3, 30);
        pul(MODE_SER_LOCAL, 1, 2, 3, 4, 5, 1'b0, 3, 59);
        for (int i = 0; i < 4; i++) begin
            pul(rnd(2) ? MODE_DCF_CET : MODE_DCF_WORLD, rnd(60), rnd(24),
                rnd(28) + 1, rnd(12) + 1, rnd(100), 1'(rnd(2)),
                rnd(25) - 12, 59);
        end
        print_verdict();
    end
endmodule
